// >>> hdl/ddrcd_fifo.sv
`timescale 1ns/10ps
module ddrcd_fifo
    import ddrcd_pkg::*;
#(
    parameter int WIDTH = 11,
    parameter int DEPTH = DDRCD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ddrcd_fptr_s;
    ddrcd_fptr_s st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // full and empty from pointers with a wrap bit
    assign in_ready = (st_reg.wp ^ st_reg.rp) != {1'b1, {AW{1'b0}}};
    assign out_valid = st_reg.wp != st_reg.rp;
    assign out_data = mem[st_reg.rp[AW-1:0]];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) st_next.wp = st_reg.wp + 1'b1;
        if (pop) st_next.rp = st_reg.rp + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) st_reg <= '0;
        else st_reg <= st_next;
        if (push) mem[st_reg.wp[AW-1:0]] <= in_data;
    end
endmodule : ddrcd_fifo

// >>> hdl/ddrcd_pkg.sv
// Notes on behaviour
// - a10 high on column access: auto precharge
// - a10 high on precharge: all banks
// - a12 low on column access chops burst
// - cs high masks every command
// - command pins latched on ck rising crossing
// - ras low, cas/we high: activate bank
// - ras low, cas high, we low: precharge
// - ras high, cas low: read/write by we
// - strobe driven with read data, edge aligned
// - termination option disables data mask
// - with termination off, masked beats never update the array
// - bank address picks the target bank
// - mode register 1 bit 11 enables termination
package ddrcd_pkg;
    localparam int DDRCD_BANKS = 8;
    localparam int DDRCD_BA_W = 3;
    localparam int DDRCD_ADDR_W = 15;
    localparam int DDRCD_AP_BIT = 10;
    localparam int DDRCD_BC_BIT = 12;
    localparam int DDRCD_TDQS_BIT = 11;
    localparam logic [2:0] DDRCD_MR1_BA = 3'h1;
    localparam logic [7:0] DDRCD_BANK_RST = 8'h00;
    localparam int DDRCD_BEATS_FULL = 8;
    localparam int DDRCD_BEATS_CHOP = 4;
    localparam int DDRCD_FIFO_DEPTH = 16;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [DDRCD_BA_W-1:0] ba;
        logic [DDRCD_ADDR_W-1:0] addr;
    } ddrcd_cmd_s;

    // one beat of write data with its bank, written to the array side
    typedef struct packed {
        logic [DDRCD_BA_W-1:0] bank;
        logic [7:0] data;
    } ddrcd_beat_s;
endpackage : ddrcd_pkg

// >>> hdl/ddrcd_top.sv
`timescale 1ns/10ps
module ddrcd_top
    import ddrcd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire logic LINK_CK,
    input wire ddrcd_cmd_s CMD,
    input wire logic DQS_IN,
    input wire logic [7:0] DQ_IN,
    input wire logic DM_IN,
    input wire logic [7:0] RD_DATA,
    input wire logic WR_READY,
    output logic DQS_OUT,
    output logic DQS_OE_N,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE_N,
    output logic TDQS_TERM,
    output logic [DDRCD_BANKS-1:0] BANK_OPEN,
    output logic WR_VALID,
    output ddrcd_beat_s WR_BEAT,
    output logic FIFO_FULL
);
    // pin sampling: two stages before any logic looks at the link pins; RD_DATA and WR_READY are used unsampled
    typedef struct packed {
        logic [1:0] ck;
        ddrcd_cmd_s cmd1;
        ddrcd_cmd_s cmd2;
        logic [1:0] dqs;
        logic [7:0] dq1;
        logic [7:0] dq2;
        logic dm1;
        logic dm2;
    } ddrcd_sync_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RD = 3'b010,
        ST_WR = 3'b100
    } ddrcd_state_e;

    typedef struct packed {
        logic ck_d;
        logic dqs_d;
        ddrcd_state_e state;
        logic [3:0] beats;
        logic ap;
        logic [DDRCD_BA_W-1:0] bank;
        logic [DDRCD_BANKS-1:0] open;
        logic tdqs;
        logic dqs_o;
        logic oe_n;
        logic [7:0] dq_o;
        logic push;
        logic [7:0] wdata;
        logic full;
    } ddrcd_core_s;

    ddrcd_sync_s sy_reg, sy_next;
    ddrcd_core_s st_reg, st_next;
    ddrcd_cmd_s c;
    logic ck_rise, ck_edge, dqs_edge, fifo_ready;
    logic is_act, is_pre, is_rd, is_wr, is_mrs;

    ////////////////////////////////////////////////////////////////
    // synchroniser: first stages feed only the second stages
    always_comb begin
        sy_next.ck = {sy_reg.ck[0], LINK_CK};
        sy_next.cmd1 = CMD;
        sy_next.cmd2 = sy_reg.cmd1;
        sy_next.dqs = {sy_reg.dqs[0], DQS_IN};
        sy_next.dq1 = DQ_IN;
        sy_next.dq2 = sy_reg.dq1;
        sy_next.dm1 = DM_IN;
        sy_next.dm2 = sy_reg.dm1;
    end

    ////////////////////////////////////////////////////////////////
    // command decode on the rising crossing of the link clock
    assign c = sy_reg.cmd2;
    assign ck_rise = sy_reg.ck[1] && !st_reg.ck_d;
    assign ck_edge = sy_reg.ck[1] != st_reg.ck_d;
    assign dqs_edge = sy_reg.dqs[1] != st_reg.dqs_d;
    // cs high masks everything, cs is part of the code
    assign is_act = ck_rise && !c.cs_n && !c.ras_n && c.cas_n && c.we_n;
    assign is_pre = ck_rise && !c.cs_n && !c.ras_n && c.cas_n && !c.we_n;
    assign is_rd = ck_rise && !c.cs_n && c.ras_n && !c.cas_n && c.we_n;
    assign is_wr = ck_rise && !c.cs_n && c.ras_n && !c.cas_n && !c.we_n;
    assign is_mrs = ck_rise && !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n;

    ////////////////////////////////////////////////////////////////
    // bank state, burst engine and strobe
    always_comb begin
        st_next = st_reg;
        st_next.ck_d = sy_reg.ck[1];
        st_next.dqs_d = sy_reg.dqs[1];
        st_next.push = 1'b0;
        st_next.full = !fifo_ready;
        // mode register 1 write sets the termination option
        if (is_mrs && c.ba == DDRCD_MR1_BA) st_next.tdqs = c.addr[DDRCD_TDQS_BIT];
        if (is_act) st_next.open[c.ba] = 1'b1;
        if (is_pre) begin
            if (c.addr[DDRCD_AP_BIT]) st_next.open = DDRCD_BANK_RST;
            else st_next.open[c.ba] = 1'b0;
        end
        // a column access only starts when the engine is free
        if ((is_rd || is_wr) && st_reg.state == ST_IDLE) begin
            st_next.state = is_rd ? ST_RD : ST_WR;
            st_next.bank = c.ba;
            st_next.ap = c.addr[DDRCD_AP_BIT];
            st_next.beats = c.addr[DDRCD_BC_BIT] ? 4'(DDRCD_BEATS_FULL) : 4'(DDRCD_BEATS_CHOP);
            st_next.oe_n = !is_rd;
            st_next.dqs_o = 1'b0;
        end
        case (st_reg.state)
            ST_RD: begin
                // data and strobe change together: edge aligned
                if (ck_edge) begin
                    st_next.dqs_o = !st_reg.dqs_o;
                    st_next.dq_o = RD_DATA;
                    st_next.beats = st_reg.beats - 4'h1;
                end
            end
            ST_WR: begin
                if (dqs_edge) begin
                    st_next.beats = st_reg.beats - 4'h1;
                    // with termination on, the mask pin is ignored
                    st_next.push = st_reg.tdqs || !sy_reg.dm2;
                    st_next.wdata = sy_reg.dq2;
                end
            end
            default: ;
        endcase
        if (st_reg.state != ST_IDLE && st_reg.beats == 4'h0) begin
            st_next.state = ST_IDLE;
            st_next.oe_n = 1'b1;
            if (st_reg.ap) st_next.open[st_reg.bank] = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            sy_reg <= '0;
            st_reg <= '{state: ST_IDLE, oe_n: 1'b1, open: DDRCD_BANK_RST, default: '0};
        end else if (CLK_EN) begin
            sy_reg <= sy_next;
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // write beats buffered toward the array; overflow beats are dropped
    ddrcd_fifo #(.WIDTH($bits(ddrcd_beat_s)), .DEPTH(DDRCD_FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .ce(CLK_EN),
        .in_valid(st_reg.push),
        .in_ready(fifo_ready),
        .in_data({st_reg.bank, st_reg.wdata}),
        .out_valid(WR_VALID),
        .out_ready(WR_READY),
        .out_data(WR_BEAT)
    );

    assign DQS_OUT = st_reg.dqs_o;
    assign DQS_OE_N = st_reg.oe_n;
    assign DQ_OUT = st_reg.dq_o;
    assign DQ_OE_N = st_reg.oe_n;
    assign TDQS_TERM = st_reg.tdqs;
    assign BANK_OPEN = st_reg.open;
    assign FIFO_FULL = st_reg.full;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N || !CLK_EN);

    a_act_opens: assert property (is_act |=> st_reg.open[$past(c.ba)]) else $error("activate missed");
    a_cs_masks: assert property (c.cs_n |-> !(is_act || is_pre || is_rd || is_wr)) else $error("cs ignored");
    a_pre_all: assert property (is_pre && c.addr[DDRCD_AP_BIT] |=> st_reg.open == 8'h00) else $error("all pre");
    a_pre_one: assert property (is_pre && !c.addr[DDRCD_AP_BIT] |=> !st_reg.open[$past(c.ba)]) else $error("pre");
    a_chop_len: assert property ((is_rd || is_wr) && st_reg.state == ST_IDLE && !c.addr[DDRCD_BC_BIT]
        |=> st_reg.beats == 4'h4) else $error("chop length");
    a_rd_drive: assert property (st_reg.state == ST_RD && st_reg.beats != 4'h0 |-> !DQS_OE_N) else $error("oe");
    a_mask_drop: assert property (st_reg.state == ST_WR && dqs_edge && sy_reg.dm2 && !st_reg.tdqs
        |=> !st_reg.push) else $error("masked beat stored");
    a_tdqs_set: assert property (is_mrs && c.ba == DDRCD_MR1_BA |=> TDQS_TERM == $past(c.addr[11])) else $error("mr1");
    a_ap_close: assert property (st_reg.state != ST_IDLE && st_reg.beats == 4'h0 && st_reg.ap && !is_act
        |=> !st_reg.open[$past(st_reg.bank)]) else $error("auto precharge");
    c_read: cover property (is_rd ##[1:200] st_reg.state == ST_IDLE);
    c_write: cover property (is_wr ##[1:200] WR_VALID);
    c_pre_all: cover property (is_pre && c.addr[DDRCD_AP_BIT]);
endmodule : ddrcd_top

// >>> tb/ddrcd_ctrl_model.sv
`timescale 1ns/10ps
module ddrcd_ctrl_model
    import ddrcd_pkg::*;
(
    input wire logic clk,
    output logic ck,
    output ddrcd_cmd_s cmd,
    output logic dqs,
    output logic [7:0] dq,
    output logic dm
);
    // idle levels at time zero
    initial begin
        ck = 1'b0;
        cmd = '1;
        dqs = 1'b0;
        dq = 8'h00;
        dm = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // ck runs only inside a frame; beats every 4 cycles
    task automatic frame(input ddrcd_cmd_s c, input int n, input logic [7:0] m, input logic w);
        cmd <= c;
        repeat (4) @(posedge clk);
        ck <= 1'b1;
        repeat (4) @(posedge clk);
        ck <= 1'b0;
        cmd <= {1'b1, ~c[$bits(c)-2:0]};
        for (int i = 0; i < n; i++) begin
            dq <= 8'h30 + 8'(i);
            dm <= m[i];
            repeat (2) @(posedge clk);
            ck <= ~ck;
            if (w) begin
                dqs <= ~dqs;
            end
            repeat (2) @(posedge clk);
        end
        dq <= ~dq; // released bus never holds its last value
        repeat (12) @(posedge clk);
    endtask : frame
endmodule : ddrcd_ctrl_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
    import ddrcd_pkg::*;
    localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, RDC = 4'h5, WRC = 4'h4, MRS = 4'h0, DES = 4'hb;
    localparam logic [14:0] A10 = 15'h0400, A11 = 15'h0800, A12 = 15'h1000;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic ck, dqs, dm, wr_ready, dqs_out, dqs_oe_n, dq_oe_n, tdqs, wr_valid, full, dqs_prev;
    logic [7:0] dq, rd_data, dq_out, bank_open, rd_last;
    ddrcd_cmd_s cmd;
    ddrcd_beat_s beat, last_beat;
    int num_errors = 0, checks = 0, stored = 0, rd_edges = 0;
    always #50 sys_clk = ~sys_clk;
    ddrcd_ctrl_model u_ctrl (.clk(sys_clk), .ck(ck), .cmd(cmd), .dqs(dqs), .dq(dq), .dm(dm));
    ddrcd_top u_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .LINK_CK(ck), .CMD(cmd),
        .DQS_IN(dqs), .DQ_IN(dq), .DM_IN(dm), .RD_DATA(rd_data), .WR_READY(wr_ready), .DQS_OUT(dqs_out),
        .DQS_OE_N(dqs_oe_n), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .TDQS_TERM(tdqs), .BANK_OPEN(bank_open),
        .WR_VALID(wr_valid), .WR_BEAT(beat), .FIFO_FULL(full));
    ////////////////////////////////////////////////////////////
    // tallies of stored beats and read strobe edges
    always @(posedge sys_clk) begin
        dqs_prev <= dqs_out;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            stored <= stored + 1;
            last_beat <= beat;
        end
        if (dq_oe_n === 1'b0) begin
            rd_last <= dq_out;
        end
        if (dqs_oe_n === 1'b0 && dqs_out !== dqs_prev) begin
            rd_edges <= rd_edges + 1;
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic f(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a, input int n = 0,
        input logic [7:0] m = 8'h00, input logic w = 1'b0);
        u_ctrl.frame({c, b, a}, n, m, w);
    endtask : f
    ////////////////////////////////////////////////////////////
    task automatic t_banks;
        f(ACT, 3'h3, 15'h0000);
        f(ACT, 3'h5, 15'h0000);
        cmp(bank_open, 8'h28);
        f(PRE, 3'h3, 15'h0000);
        cmp(bank_open, 8'h20);
        f(DES, 3'h1, 15'h0000);
        cmp(bank_open, 8'h20);
        f(PRE, 3'h0, A10);
        cmp(bank_open, 8'h00);
        // frozen clock enable: the crossing is never sampled, so no activate
        clk_en <= 1'b0;
        f(ACT, 3'h7, 15'h0000);
        clk_en <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmp(bank_open, 8'h00);
    endtask : t_banks
    task automatic t_write;
        int s0;
        f(ACT, 3'h2, 15'h0000);
        s0 = stored;
        f(WRC, 3'h2, 15'h0000, 4, 8'h05, 1'b1);
        cmp(8'(stored - s0), 8'h02);
        cmp(last_beat.data, 8'h33);
        cmp(8'(last_beat.bank), 8'h02);
        cmp(bank_open, 8'h04);
        s0 = stored;
        f(WRC, 3'h2, A10 | A12, 8, 8'h00, 1'b1);
        cmp(8'(stored - s0), 8'h08);
        cmp(bank_open, 8'h00);
    endtask : t_write
    // array stalls: two full bursts fill the buffer, a third is refused
    task automatic t_fifo;
        int s0;
        wr_ready <= 1'b0;
        f(ACT, 3'h6, 15'h0000);
        s0 = stored;
        f(WRC, 3'h6, A12, 8, 8'h00, 1'b1);
        f(WRC, 3'h6, A12, 8, 8'h00, 1'b1);
        cmp({7'h00, full}, 8'h01);
        f(WRC, 3'h6, 15'h0000, 4, 8'h00, 1'b1);
        wr_ready <= 1'b1;
        repeat (24) @(posedge sys_clk);
        cmp(8'(stored - s0), 8'h10);
        cmp({7'h00, full}, 8'h00);
        f(PRE, 3'h0, A10);
    endtask : t_fifo
    task automatic t_term;
        int s0;
        f(MRS, DDRCD_MR1_BA, A11);
        cmp({7'h00, tdqs}, 8'h01);
        f(ACT, 3'h0, 15'h0000);
        s0 = stored;
        f(WRC, 3'h0, A10, 4, 8'h0f, 1'b1);
        cmp(8'(stored - s0), 8'h04);
        f(MRS, DDRCD_MR1_BA, 15'h0000);
        cmp({7'h00, tdqs}, 8'h00);
    endtask : t_term
    task automatic t_read;
        int e0;
        rd_data <= 8'h5a;
        f(ACT, 3'h1, 15'h0000);
        e0 = rd_edges;
        f(RDC, 3'h1, 15'h0000, 4);
        cmp(8'(rd_edges - e0), 8'h04);
        cmp(rd_last, 8'h5a);
        cmp(bank_open, 8'h02);
        e0 = rd_edges;
        f(RDC, 3'h1, A10 | A12, 8);
        cmp(8'(rd_edges - e0), 8'h08);
        cmp(bank_open, 8'h00);
        cmp({7'h00, dqs_oe_n}, 8'h01);
    endtask : t_read
    task automatic results;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    initial begin
        rd_data = 8'h00;
        wr_ready = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_banks;
        t_write;
        t_fifo;
        t_term;
        t_read;
        results;
    end
    // run needs about 650 cycles; the limit is about fifteen times that
    initial begin
        #1000000;
        num_errors++;
        results;
    end
endmodule : tb
